// >>> rtl/mmfc_addr_decode.v
/*
 * Combinational address decode for the core: external data space, internal
 * data space, register bank selection, bit-addressable area and vector entries.
 * Assumes the caller registers whatever it drives out of the block.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mmfc_consts.vh"

module mmfc_addr_decode (
	input wire [15:0] i_xaddr,
	input wire [7:0] i_iaddr,
	input wire i_indirect,
	input wire [1:0] i_bank,
	input wire [2:0] i_reg_num,
	input wire [7:0] i_bit_addr,
	input wire [3:0] i_vec_index,
	output wire o_aux_data_ram_hit,
	output wire o_periph_hit,
	output wire o_sfr_sel,
	output wire o_core_data_ram_sel,
	output wire [7:0] o_reg_iaddr,
	output wire o_bit_in_ram,
	output wire [7:0] o_bit_byte_addr,
	output wire [2:0] o_bit_index,
	output wire [15:0] o_vec_addr
);

	// Only these two ranges are backed; anything else answers as unmapped.
	assign o_aux_data_ram_hit = (i_xaddr <= `MMFC_AUX_DATA_RAM_LAST); // R3
	assign o_periph_hit = (i_xaddr >= `MMFC_PERIPH_FIRST); // R3

	// The upper half is shared: direct reaches special registers, indirect reaches RAM.
	assign o_sfr_sel = (i_iaddr >= `MMFC_CORE_DATA_RAM_UPPER_FIRST) && !i_indirect; // R18
	assign o_core_data_ram_sel = !o_sfr_sel; // R18

	assign o_reg_iaddr = {3'b000, i_bank, i_reg_num}; // R19

	// Bit addresses with the top bit set belong to special registers.
	assign o_bit_in_ram = !i_bit_addr[7]; // R20
	assign o_bit_byte_addr = `MMFC_BIT_AREA_BASE + {4'b0000, i_bit_addr[6:3]}; // R20
	assign o_bit_index = i_bit_addr[2:0]; // R20

	assign o_vec_addr = `MMFC_FIRST_VECTOR + {9'b0_0000_0000, i_vec_index, 3'b000}; // R2

endmodule // mmfc_addr_decode

`default_nettype wire

// >>> rtl/mmfc_consts.vh
/*
 * Constants for the memory map and flash control block: special register
 * addresses, field positions, command patterns, address ranges and reset values.
 * Assumes it is included by bare name from the block's design files.
 */
`ifndef MMFC_CONSTS_VH
`define MMFC_CONSTS_VH

`define MMFC_SFR_WIPE_COMMAND 8'h94
`define MMFC_SFR_NVM_CONTROL 8'hb2
`define MMFC_SFR_PAGE_SELECT 8'hb7

`define MMFC_BIT_PROG_ARM 0
`define MMFC_BIT_BULK_ARM 1
`define MMFC_BIT_CODE_LOCK 6

`define MMFC_PAT_PAGE_WIPE 8'h55
`define MMFC_PAT_BULK_WIPE 8'haa

`define MMFC_RST_PAGE_SELECT 8'h00
`define MMFC_RST_NVM_CONTROL 8'h00
`define MMFC_RST_SFR_RDATA 8'h00

`define MMFC_RESET_VECTOR 16'h0000
`define MMFC_FIRST_VECTOR 16'h0003
`define MMFC_VECTOR_SHIFT 3

`define MMFC_PAGE_OFFSET_BITS 9
`define MMFC_PAGE_SEL_MSB 7
`define MMFC_PAGE_SEL_LSB 1

`define MMFC_AUX_DATA_RAM_LAST 16'h07ff
`define MMFC_PERIPH_FIRST 16'hfc00
`define MMFC_AUX_DATA_RAM_AW 11
`define MMFC_PERIPH_AW 10

`define MMFC_CORE_DATA_RAM_UPPER_FIRST 8'h80
`define MMFC_BIT_AREA_BASE 8'h20

`endif

// >>> rtl/mmfc_flash_ctrl.v
/*
 * Memory map and flash wipe/program sequencer sitting beside the core.
 * Holds the wipe command, page select and nvm control special registers,
 * routes external data moves to data RAM, peripherals or flash, and gates
 * debug reads with the code lock.
 * Assumes the core raises one special register or data move request per cycle,
 * holds it while stalled, and that the flash array answers each start pulse
 * with a done pulse no earlier than the next cycle.
 */
//
// Contract
// R1: After reset fetching starts at address zero; only fetches and code moves read program.
// R2: Interrupt vectors sit in low program memory, eight bytes apart, starting at three.
// R3: External data 0000-07FF is data RAM, FC00-FFFF peripherals; nothing else backed.
// R4: Bulk wipe needs the bulk arm bit set, then 0xAA to wipe command.
// R5: Bulk wipe is refused unless the debug port is enabled when 0xAA arrives; the code checks the pin as synchronised, two cycles earlier.
// R6: Page wipe needs a page select write, then 0x55 to wipe command.
// R7: Flash is 128 pages of 512 bytes; page wipe clears exactly one.
// R8: Page select bits 7:1 give flash address bits 15:9; bit 0 ignored.
// R9: Any other wipe command value does nothing and changes no state.
// R10: Software rewrites page select before every page wipe.
// R11: Software sets the bulk arm bit again before every bulk wipe.
// R12: Arm clear sends data writes to RAM; arm set sends pointer writes to flash.
// R13: The program arm bit clears itself after each programmed byte.
// R14: Program arm writes are ignored while interrupts are enabled.
// R15: Code lock clears on reset, can only be set; writing zero does nothing.
// R16: While locked, debug reads of flash and program RAM are blocked.
// R17: Software sets the cpu clock to 3.6923 MHz before any flash operation.
// R18: Upper internal addresses are special registers directly, RAM indirectly.
// R19: Lowest 32 bytes are four banks of eight registers chosen by two status bits.
// R20: The 16 bytes after the banks are bit addressable as bits 0x00-0x7F.
// R21: While a wipe or program runs the core stalls and commands are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "mmfc_consts.vh"

module mmfc_flash_ctrl (
	input wire i_sys_clk,
	input wire i_reset,
	input wire i_sfr_wr,
	input wire i_sfr_rd,
	input wire [7:0] i_sfr_addr,
	input wire [7:0] i_sfr_wdata,
	output wire o_sfr_hit,
	output wire [7:0] o_sfr_rdata,
	input wire i_irq_enabled,
	input wire i_debug_port_en,
	input wire i_xdata_wr,
	input wire i_xdata_rd,
	input wire i_xdata_data_pointer,
	input wire [15:0] i_xdata_addr,
	input wire [7:0] i_xdata_wdata,
	output wire o_aux_data_ram_we,
	output wire o_aux_data_ram_re,
	output wire [10:0] o_aux_data_ram_addr,
	output wire o_periph_we,
	output wire o_periph_re,
	output wire [9:0] o_periph_addr,
	output wire [7:0] o_xdata_wdata,
	output wire o_xdata_unmapped,
	input wire i_fetch_req,
	input wire i_code_move,
	input wire [15:0] i_prog_addr,
	output wire o_prog_rd_en,
	output wire [15:0] o_prog_rd_addr,
	input wire i_vec_take,
	input wire [3:0] i_vec_index,
	output wire [15:0] o_entry_addr,
	input wire [7:0] i_iaddr,
	input wire i_indirect,
	input wire [1:0] i_bank,
	input wire [2:0] i_reg_num,
	input wire [7:0] i_bit_addr,
	output wire o_sfr_sel,
	output wire o_core_data_ram_sel,
	output wire [7:0] o_reg_iaddr,
	output wire o_bit_in_ram,
	output wire [7:0] o_bit_byte_addr,
	output wire [2:0] o_bit_index,
	output wire o_flash_erase_page,
	output wire o_flash_erase_all,
	output wire [15:0] o_flash_erase_addr,
	output wire o_flash_prog,
	output wire [15:0] o_flash_prog_addr,
	output wire [7:0] o_flash_prog_data,
	input wire i_flash_done,
	output wire o_core_stall,
	input wire i_dbg_rd_req,
	output wire o_dbg_rd_grant,
	output wire o_code_lock
);

	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_PAGE = 4'b0010;
	localparam [3:0] ST_BULK = 4'b0100;
	localparam [3:0] ST_PROG = 4'b1000;

	reg [3:0] state_ff;
	reg [3:0] nxt_state;
	reg [7:0] page_ff;
	reg page_fresh_ff;
	reg bulk_arm_ff;
	reg prog_arm_ff;
	reg lock_ff;
	reg dbg_meta_ff;
	reg dbg_sync_ff;
	reg [7:0] sfr_rdata_ff;
	reg erase_page_ff;
	reg erase_all_ff;
	reg [15:0] erase_addr_ff;
	reg prog_ff;
	reg [15:0] prog_addr_ff;
	reg [7:0] prog_data_ff;
	reg aux_data_ram_we_ff;
	reg aux_data_ram_re_ff;
	reg [10:0] aux_data_ram_addr_ff;
	reg periph_we_ff;
	reg periph_re_ff;
	reg [9:0] periph_addr_ff;
	reg [7:0] xdata_wdata_ff;
	reg unmapped_ff;
	reg prog_rd_en_ff;
	reg [15:0] prog_rd_addr_ff;
	reg [15:0] entry_addr_ff;
	reg sfr_sel_ff;
	reg core_data_ram_sel_ff;
	reg [7:0] reg_iaddr_ff;
	reg bit_in_ram_ff;
	reg [7:0] bit_byte_addr_ff;
	reg [2:0] bit_index_ff;

	wire aux_data_ram_hit;
	wire periph_hit;
	wire dec_sfr_sel;
	wire dec_core_data_ram_sel;
	wire [7:0] dec_reg_iaddr;
	wire dec_bit_in_ram;
	wire [7:0] dec_bit_byte_addr;
	wire [2:0] dec_bit_index;
	wire [15:0] dec_vec_addr;

	wire idle = (state_ff == ST_IDLE);
	wire wr_wipe = i_sfr_wr && (i_sfr_addr == `MMFC_SFR_WIPE_COMMAND);
	wire wr_ctrl = i_sfr_wr && (i_sfr_addr == `MMFC_SFR_NVM_CONTROL);
	wire wr_page = i_sfr_wr && (i_sfr_addr == `MMFC_SFR_PAGE_SELECT);
	wire pat_page = (i_sfr_wdata == `MMFC_PAT_PAGE_WIPE);
	wire pat_bulk = (i_sfr_wdata == `MMFC_PAT_BULK_WIPE);
	wire start_page = idle && wr_wipe && pat_page && page_fresh_ff; // R6
	wire start_bulk = idle && wr_wipe && pat_bulk && bulk_arm_ff && dbg_sync_ff; // R4 R5
	wire start_prog = idle && i_xdata_wr && i_xdata_data_pointer && prog_arm_ff; // R12
	wire to_xdata = idle && !start_prog;

	mmfc_addr_decode u_decode (
		.i_xaddr(i_xdata_addr),
		.i_iaddr(i_iaddr),
		.i_indirect(i_indirect),
		.i_bank(i_bank),
		.i_reg_num(i_reg_num),
		.i_bit_addr(i_bit_addr),
		.i_vec_index(i_vec_index),
		.o_aux_data_ram_hit(aux_data_ram_hit),
		.o_periph_hit(periph_hit),
		.o_sfr_sel(dec_sfr_sel),
		.o_core_data_ram_sel(dec_core_data_ram_sel),
		.o_reg_iaddr(dec_reg_iaddr),
		.o_bit_in_ram(dec_bit_in_ram),
		.o_bit_byte_addr(dec_bit_byte_addr),
		.o_bit_index(dec_bit_index),
		.o_vec_addr(dec_vec_addr)
	);

	// The debug enable comes from a pin, so it is synchronised before use.
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			dbg_meta_ff <= 1'b0;
			dbg_sync_ff <= 1'b0;
		end else begin
			dbg_meta_ff <= i_debug_port_en;
			dbg_sync_ff <= dbg_meta_ff;
		end
	end

	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start_bulk)
					nxt_state = ST_BULK;
				else if (start_page)
					nxt_state = ST_PAGE;
				else if (start_prog)
					nxt_state = ST_PROG;
			end
			ST_PAGE, ST_BULK, ST_PROG: begin
				if (i_flash_done)
					nxt_state = ST_IDLE; // R21
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			state_ff <= ST_IDLE;
			page_ff <= `MMFC_RST_PAGE_SELECT;
			page_fresh_ff <= 1'b0;
			bulk_arm_ff <= 1'b0;
			prog_arm_ff <= 1'b0;
			lock_ff <= 1'b0; // R15
		end else begin
			state_ff <= nxt_state;
			// A page address is consumed by the wipe it starts.
			if (start_page)
				page_fresh_ff <= 1'b0; // R10
			if (wr_page && idle) begin
				page_ff <= i_sfr_wdata;
				page_fresh_ff <= 1'b1;
			end
			// A bulk pattern consumes the arm even when refused, so no arm lingers.
			if (wr_wipe && pat_bulk && idle)
				bulk_arm_ff <= 1'b0; // R11
			if (start_prog)
				prog_arm_ff <= 1'b0; // R13
			if (wr_ctrl && idle) begin
				if (!wr_wipe)
					bulk_arm_ff <= i_sfr_wdata[`MMFC_BIT_BULK_ARM]; // R4
				if (!i_irq_enabled)
					prog_arm_ff <= i_sfr_wdata[`MMFC_BIT_PROG_ARM]; // R14
				if (i_sfr_wdata[`MMFC_BIT_CODE_LOCK])
					lock_ff <= 1'b1; // R15
			end
		end
	end

	// Wipe command reads as zero since it is write only; unknown addresses are not claimed.
	assign o_sfr_hit = (i_sfr_addr == `MMFC_SFR_WIPE_COMMAND) ||
		(i_sfr_addr == `MMFC_SFR_NVM_CONTROL) || (i_sfr_addr == `MMFC_SFR_PAGE_SELECT);

	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			sfr_rdata_ff <= `MMFC_RST_SFR_RDATA;
		end else if (i_sfr_rd) begin
			case (i_sfr_addr)
				`MMFC_SFR_NVM_CONTROL: sfr_rdata_ff <= {1'b0, lock_ff, 4'b0000, bulk_arm_ff,
					prog_arm_ff};
				`MMFC_SFR_PAGE_SELECT: sfr_rdata_ff <= page_ff;
				default: sfr_rdata_ff <= `MMFC_RST_SFR_RDATA;
			endcase
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			erase_page_ff <= 1'b0;
			erase_all_ff <= 1'b0;
			erase_addr_ff <= 16'h0000;
			prog_ff <= 1'b0;
			prog_addr_ff <= 16'h0000;
			prog_data_ff <= 8'h00;
		end else begin
			// Other patterns fall through here and start nothing.
			erase_page_ff <= start_page && !start_bulk; // R9
			erase_all_ff <= start_bulk; // R9
			prog_ff <= start_prog;
			if (start_page)
				erase_addr_ff <= {page_ff[`MMFC_PAGE_SEL_MSB:`MMFC_PAGE_SEL_LSB],
					{`MMFC_PAGE_OFFSET_BITS{1'b0}}}; // R7 R8
			if (start_prog) begin
				prog_addr_ff <= i_xdata_addr; // R12
				prog_data_ff <= i_xdata_wdata; // R12
			end
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			aux_data_ram_we_ff <= 1'b0;
			aux_data_ram_re_ff <= 1'b0;
			aux_data_ram_addr_ff <= 11'h000;
			periph_we_ff <= 1'b0;
			periph_re_ff <= 1'b0;
			periph_addr_ff <= 10'h000;
			xdata_wdata_ff <= 8'h00;
			unmapped_ff <= 1'b0;
		end else begin
			aux_data_ram_we_ff <= to_xdata && i_xdata_wr && aux_data_ram_hit; // R3 R12
			aux_data_ram_re_ff <= to_xdata && i_xdata_rd && aux_data_ram_hit; // R3
			periph_we_ff <= to_xdata && i_xdata_wr && periph_hit; // R3
			periph_re_ff <= to_xdata && i_xdata_rd && periph_hit; // R3
			unmapped_ff <= to_xdata && (i_xdata_wr || i_xdata_rd) && !aux_data_ram_hit &&
				!periph_hit; // R3
			aux_data_ram_addr_ff <= i_xdata_addr[`MMFC_AUX_DATA_RAM_AW-1:0];
			periph_addr_ff <= i_xdata_addr[`MMFC_PERIPH_AW-1:0];
			xdata_wdata_ff <= i_xdata_wdata;
		end
	end

	// Program space has no data-move read path; only fetch and code move reach it.
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			prog_rd_en_ff <= 1'b0;
			prog_rd_addr_ff <= `MMFC_RESET_VECTOR;
			entry_addr_ff <= `MMFC_RESET_VECTOR; // R1
		end else begin
			prog_rd_en_ff <= idle && (i_fetch_req || i_code_move); // R1
			if (idle && (i_fetch_req || i_code_move))
				prog_rd_addr_ff <= i_prog_addr;
			if (i_vec_take)
				entry_addr_ff <= dec_vec_addr; // R2
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			sfr_sel_ff <= 1'b0;
			core_data_ram_sel_ff <= 1'b0;
			reg_iaddr_ff <= 8'h00;
			bit_in_ram_ff <= 1'b0;
			bit_byte_addr_ff <= 8'h00;
			bit_index_ff <= 3'b000;
		end else begin
			sfr_sel_ff <= dec_sfr_sel; // R18
			core_data_ram_sel_ff <= dec_core_data_ram_sel; // R18
			reg_iaddr_ff <= dec_reg_iaddr; // R19
			bit_in_ram_ff <= dec_bit_in_ram; // R20
			bit_byte_addr_ff <= dec_bit_byte_addr; // R20
			bit_index_ff <= dec_bit_index; // R20
		end
	end

	// Stalling the core is simpler than queueing commands behind an unknown wipe time.
	assign o_core_stall = !idle; // R21
	assign o_dbg_rd_grant = i_dbg_rd_req && !lock_ff; // R16
	assign o_code_lock = lock_ff;
	assign o_sfr_rdata = sfr_rdata_ff;
	assign o_flash_erase_page = erase_page_ff;
	assign o_flash_erase_all = erase_all_ff;
	assign o_flash_erase_addr = erase_addr_ff;
	assign o_flash_prog = prog_ff;
	assign o_flash_prog_addr = prog_addr_ff;
	assign o_flash_prog_data = prog_data_ff;
	assign o_aux_data_ram_we = aux_data_ram_we_ff;
	assign o_aux_data_ram_re = aux_data_ram_re_ff;
	assign o_aux_data_ram_addr = aux_data_ram_addr_ff;
	assign o_periph_we = periph_we_ff;
	assign o_periph_re = periph_re_ff;
	assign o_periph_addr = periph_addr_ff;
	assign o_xdata_wdata = xdata_wdata_ff;
	assign o_xdata_unmapped = unmapped_ff;
	assign o_prog_rd_en = prog_rd_en_ff;
	assign o_prog_rd_addr = prog_rd_addr_ff;
	assign o_entry_addr = entry_addr_ff;
	assign o_sfr_sel = sfr_sel_ff;
	assign o_core_data_ram_sel = core_data_ram_sel_ff;
	assign o_reg_iaddr = reg_iaddr_ff;
	assign o_bit_in_ram = bit_in_ram_ff;
	assign o_bit_byte_addr = bit_byte_addr_ff;
	assign o_bit_index = bit_index_ff;

endmodule // mmfc_flash_ctrl

`default_nettype wire

// >>> sim/mmfc_asserts.sv
/* Port checker for mmfc_flash_ctrl.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module mmfc_asserts (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_addr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic i_debug_port_en,
	input wire logic i_xdata_rd,
	input wire logic [15:0] i_xdata_addr,
	input wire logic o_aux_data_ram_re,
	input wire logic o_periph_re,
	input wire logic o_xdata_unmapped,
	input wire logic i_vec_take,
	input wire logic [3:0] i_vec_index,
	input wire logic [15:0] o_entry_addr,
	input wire logic o_flash_erase_page,
	input wire logic o_flash_erase_all,
	input wire logic [15:0] o_flash_erase_addr,
	input wire logic o_flash_prog,
	input wire logic i_flash_done,
	input wire logic o_core_stall,
	input wire logic i_dbg_rd_req,
	input wire logic o_dbg_rd_grant,
	input wire logic o_code_lock
);
default clocking @(posedge i_sys_clk); endclocking
default disable iff (i_reset);
logic wipe_wr;
assign wipe_wr = i_sfr_wr && i_sfr_addr == 8'h94 && !o_core_stall;
a_grant_gate: assert property (o_dbg_rd_grant == (i_dbg_rd_req && !o_code_lock))
	else $error("debug grant wrong");
a_lock_sticky: assert property (o_code_lock |=> o_code_lock)
	else $error("lock cleared");
a_page_align: assert property (o_flash_erase_page |-> o_flash_erase_addr[8:0] == 9'h000)
	else $error("page address not aligned");
a_other_pattern: assert property (wipe_wr && i_sfr_wdata != 8'h55 && i_sfr_wdata != 8'haa
	|=> !o_flash_erase_page && !o_flash_erase_all && !o_core_stall) else $error("bad pattern acted");
a_busy_refuse: assert property (o_core_stall && $past(o_core_stall)
	|-> !o_flash_erase_page && !o_flash_erase_all && !o_flash_prog) else $error("start while busy");
a_done_release: assert property (i_flash_done && o_core_stall |=> !o_core_stall)
	else $error("stall held after done");
a_bulk_debug: assert property (!i_debug_port_en [*3] ##0 (wipe_wr && i_sfr_wdata == 8'haa)
	|=> !o_flash_erase_all) else $error("bulk wipe without debug");
a_unmapped_hole: assert property (i_xdata_rd && !o_core_stall
	&& i_xdata_addr inside {[16'h0800:16'hfbff]}
	|=> o_xdata_unmapped && !o_aux_data_ram_re && !o_periph_re) else $error("hole decoded");
a_vec_entry: assert property (i_vec_take
	|=> o_entry_addr == 16'h0003 + {9'h000, $past(i_vec_index), 3'b000}) else $error("bad vector");
endmodule // mmfc_asserts
`default_nettype wire

// >>> sim/mmfc_flash_ctrl_tb.sv
/* Self-checking bench for mmfc_flash_ctrl with a flash array model.
   Assumes a 100 MHz clock; inputs change at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module mmfc_flash_ctrl_tb;
logic i_sys_clk = 0, i_reset = 1, i_sfr_wr = 0, i_sfr_rd = 0, i_irq_enabled = 0;
logic i_debug_port_en = 0, i_xdata_wr = 0, i_xdata_rd = 0, i_xdata_data_pointer = 0, i_code_move = 0;
logic i_fetch_req = 0, i_vec_take = 0, i_indirect = 0, i_dbg_rd_req = 0, i_flash_done;
logic [7:0] i_sfr_addr = 0, i_sfr_wdata = 0, i_xdata_wdata = 0, i_iaddr = 0, i_bit_addr = 0;
logic [15:0] i_xdata_addr = 0, i_prog_addr = 0;
logic [3:0] i_vec_index = 0;
logic [1:0] i_bank = 0;
logic [2:0] i_reg_num = 0, o_bit_index;
logic o_sfr_hit, o_aux_data_ram_we, o_aux_data_ram_re, o_periph_we, o_periph_re, o_xdata_unmapped, o_prog_rd_en;
logic o_sfr_sel, o_core_data_ram_sel, o_bit_in_ram, o_flash_erase_page, o_flash_erase_all, o_flash_prog;
logic o_core_stall, o_dbg_rd_grant, o_code_lock;
logic [7:0] o_sfr_rdata, o_xdata_wdata, o_reg_iaddr, o_bit_byte_addr, o_flash_prog_data;
logic [10:0] o_aux_data_ram_addr;
logic [9:0] o_periph_addr;
logic [15:0] o_prog_rd_addr, o_entry_addr, o_flash_erase_addr, o_flash_prog_addr;
int errors = 0, n_checks = 0, cyc = 0, i;
// Stand-in peripheral address for the cpu clock divider; the value is arbitrary.
localparam logic [15:0] clk_div_addr = 16'hfc44;
logic [19:0] rows [7] = '{{1'b0, 16'h0000, 3'b100}, {1'b0, 16'h07ff, 3'b100},
	{1'b0, 16'h0800, 3'b001}, {1'b0, 16'hfbff, 3'b001}, {1'b0, 16'hfc00, 3'b010},
	{1'b1, 16'hffff, 3'b010}, {1'b1, 16'h0123, 3'b100}};
mmfc_flash_ctrl dut_u (.*);
mmfc_flash_model #(.LAT(4)) flash_u (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
	.i_start(o_flash_erase_page | o_flash_erase_all | o_flash_prog), .o_done(i_flash_done));
always #5 i_sys_clk = ~i_sys_clk;
always @(posedge i_sys_clk) begin
	cyc++;
	if (cyc == 5000) begin
		errors++;
		complete_run();
	end
end
task automatic complete_run;
	$display("checks %0d errors %0d", n_checks, errors);
	if (errors == 0 && n_checks > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask
task automatic special_reg_space(input logic w, input logic [7:0] a, input logic [7:0] d);
	@(negedge i_sys_clk);
	i_sfr_wr = w;
	i_sfr_rd = !w;
	i_sfr_addr = a;
	i_sfr_wdata = d;
	@(negedge i_sys_clk);
	i_sfr_wr = 0;
	i_sfr_rd = 0;
endtask
task automatic xd(input logic w, input logic p, input logic [15:0] a, input logic [7:0] d);
	@(negedge i_sys_clk);
	i_xdata_wr = w;
	i_xdata_rd = !w;
	i_xdata_data_pointer = p;
	i_xdata_addr = a;
	i_xdata_wdata = d;
	@(negedge i_sys_clk);
	i_xdata_wr = 0;
	i_xdata_rd = 0;
endtask
task automatic wait_idle;
	for (int k = 0; k < 50 && o_core_stall; k++)
		@(negedge i_sys_clk);
	`CHK(o_core_stall, 1'b0)
endtask
initial begin
	repeat (20) @(negedge i_sys_clk);
	i_reset = 0;
	@(negedge i_sys_clk);
	`CHK(o_entry_addr, 16'h0000)
	special_reg_space(0, 8'hb2, 8'h00);
	`CHK({o_sfr_hit, o_sfr_rdata}, {1'b1, 8'h00})
	$display("reset test done");
	for (i = 0; i < 7; i++) begin
		xd(rows[i][19], 0, rows[i][18:3], 8'h5a);
		`CHK({o_aux_data_ram_we | o_aux_data_ram_re, o_periph_we | o_periph_re, o_xdata_unmapped}, rows[i][2:0])
	end
	`CHK({o_aux_data_ram_addr, o_xdata_wdata}, {11'h123, 8'h5a})
	@(negedge i_sys_clk);
	i_fetch_req = 1;
	i_prog_addr = 16'h1234;
	i_vec_take = 1;
	i_vec_index = 4'hf;
	i_bank = 2'h2;
	i_reg_num = 3'h5;
	i_bit_addr = 8'h7f;
	i_iaddr = 8'h90;
	@(negedge i_sys_clk);
	i_fetch_req = 0;
	i_vec_take = 0;
	i_indirect = 1;
	i_code_move = 1;
	i_prog_addr = 16'h5678;
	`CHK({o_prog_rd_en, o_prog_rd_addr}, {1'b1, 16'h1234})
	`CHK(o_entry_addr, 16'h007b)
	`CHK(o_reg_iaddr, 8'h15)
	`CHK({o_bit_in_ram, o_bit_byte_addr, o_bit_index}, {1'b1, 8'h2f, 3'h7})
	`CHK(o_sfr_sel, 1'b1)
	@(negedge i_sys_clk);
	i_code_move = 0;
	`CHK(o_core_data_ram_sel, 1'b1)
	`CHK({o_prog_rd_en, o_prog_rd_addr}, {1'b1, 16'h5678})
	$display("map test done");
	// The core slows its clock through a peripheral register before touching flash.
	xd(1, 0, clk_div_addr, 8'h0c);
	`CHK({o_periph_we, o_periph_addr, o_xdata_wdata}, {1'b1, 10'h044, 8'h0c})
	special_reg_space(1, 8'hb7, 8'h0b);
	special_reg_space(1, 8'h94, 8'h55);
	`CHK({o_flash_erase_page, o_flash_erase_addr, o_core_stall}, {1'b1, 16'h0a00, 1'b1})
	special_reg_space(1, 8'hb7, 8'h20);
	wait_idle();
	special_reg_space(0, 8'hb7, 8'h00);
	`CHK(o_sfr_rdata, 8'h0b)
	special_reg_space(1, 8'h94, 8'h55);
	`CHK(o_flash_erase_page, 1'b0)
	special_reg_space(1, 8'h94, 8'h12);
	`CHK({o_flash_erase_page, o_flash_erase_all, o_core_stall}, 3'b000)
	$display("page test done");
	special_reg_space(1, 8'hb2, 8'h02);
	special_reg_space(0, 8'hb2, 8'h00);
	`CHK(o_sfr_rdata, 8'h02)
	special_reg_space(1, 8'h94, 8'haa);
	`CHK(o_flash_erase_all, 1'b0)
	i_debug_port_en = 1;
	repeat (3) @(negedge i_sys_clk);
	special_reg_space(1, 8'h94, 8'haa);
	`CHK(o_flash_erase_all, 1'b0)
	special_reg_space(1, 8'hb2, 8'h02);
	special_reg_space(1, 8'h94, 8'haa);
	`CHK(o_flash_erase_all, 1'b1)
	wait_idle();
	$display("bulk test done");
	i_irq_enabled = 1;
	special_reg_space(1, 8'hb2, 8'h01);
	special_reg_space(0, 8'hb2, 8'h00);
	`CHK(o_sfr_rdata, 8'h00)
	i_irq_enabled = 0;
	special_reg_space(1, 8'hb2, 8'h01);
	xd(1, 1, 16'h4321, 8'hc3);
	`CHK({o_flash_prog, o_flash_prog_addr, o_flash_prog_data}, {1'b1, 16'h4321, 8'hc3})
	`CHK(o_aux_data_ram_we, 1'b0)
	wait_idle();
	special_reg_space(0, 8'hb2, 8'h00);
	`CHK(o_sfr_rdata, 8'h00)
	xd(1, 1, 16'h0010, 8'h00);
	`CHK(o_aux_data_ram_we, 1'b1)
	$display("program test done");
	i_dbg_rd_req = 1;
	@(negedge i_sys_clk);
	`CHK(o_dbg_rd_grant, 1'b1)
	special_reg_space(1, 8'hb2, 8'h40);
	`CHK({o_code_lock, o_dbg_rd_grant}, 2'b10)
	special_reg_space(1, 8'hb2, 8'h00);
	`CHK(o_code_lock, 1'b1)
	i_reset = 1;
	repeat (3) @(negedge i_sys_clk);
	i_reset = 0;
	@(negedge i_sys_clk);
	`CHK(o_code_lock, 1'b0)
	$display("lock test done");
	complete_run();
end
endmodule // mmfc_flash_ctrl_tb
bind mmfc_flash_ctrl mmfc_asserts chk_u (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
	.i_sfr_wr(i_sfr_wr), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
	.i_debug_port_en(i_debug_port_en), .i_xdata_rd(i_xdata_rd), .i_xdata_addr(i_xdata_addr),
	.o_aux_data_ram_re(o_aux_data_ram_re), .o_periph_re(o_periph_re), .o_xdata_unmapped(o_xdata_unmapped),
	.i_vec_take(i_vec_take), .i_vec_index(i_vec_index), .o_entry_addr(o_entry_addr),
	.o_flash_erase_page(o_flash_erase_page), .o_flash_erase_all(o_flash_erase_all),
	.o_flash_erase_addr(o_flash_erase_addr), .o_flash_prog(o_flash_prog),
	.i_flash_done(i_flash_done), .o_core_stall(o_core_stall), .i_dbg_rd_req(i_dbg_rd_req),
	.o_dbg_rd_grant(o_dbg_rd_grant), .o_code_lock(o_code_lock));
`default_nettype wire

// >>> sim/mmfc_flash_model.sv
/* Flash array stand-in: answers each start pulse with one done pulse.
   Assumes start pulses never overlap a running operation. */
`timescale 1ns/1ps
`default_nettype none
module mmfc_flash_model #(parameter int LAT = 4) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_start,
	output logic o_done
);
logic [7:0] cnt_ff;
always @(posedge i_sys_clk) begin
	o_done <= !i_reset && cnt_ff == 8'h01;
	if (i_reset)
		cnt_ff <= 8'h00;
	else if (i_start)
		cnt_ff <= 8'(LAT);
	else if (cnt_ff != 8'h00)
		cnt_ff <= cnt_ff - 8'h01;
end
endmodule // mmfc_flash_model
`default_nettype wire
